// ==== uart_host_port_and_modem_lines_tb_top.sv ====
// Self-checking testbench of the serial element host port
`timescale 1ns/1ps
`default_nettype none

module uart_host_port_and_modem_lines_tb_top;
  import ucomm_pkg::*;

  logic         clk_in = 1'b0;
  logic         reset_n_in = 1'b0;
  logic         master_reset_in = 1'b0;
  logic         cs_n, rd_n, wr_n, data_oe_out, dtr_n_out, rts_n_out;
  logic [2:0]   sel;
  logic [7:0]   wdata, data_out;
  ucomm_lines_s lines = 4'hf;
  logic [3:0]   src = 4'h0;
  logic         rx_threshold_in = 1'b0;
  logic         tx_serial_in = 1'b1;
  logic         serial_tx_out, tx_allowed_out, irq_out;
  int           mismatches = 0;
  int           total_checks = 0;
  logic [3:0]   pv [6] = '{4'he, 4'he, 4'hc, 4'h4, 4'h0, 4'h4};
  logic [7:0]   ev [6] = '{8'h11, 8'h10, 8'h32, 8'hb8, 8'hf0, 8'hb4};
  logic [7:0]   id [3] = '{8'h04, 8'h02, 8'h06};

  always #12.5 clk_in = ~clk_in;

  ucomm_host_model u_host (.clk_in(clk_in), .rdata_in(data_out), .oe_in(data_oe_out),
    .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n), .sel_out(sel), .wdata_out(wdata));

  ucomm_host_port u_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .master_reset_in(master_reset_in), .reg_select_0_in(sel[0]), .reg_select_1_in(sel[1]),
    .reg_select_2_in(sel[2]), .chip_select_n_in(cs_n), .read_strobe_n_in(rd_n),
    .write_strobe_n_in(wr_n), .data_in(wdata), .data_out(data_out),
    .data_oe_out(data_oe_out), .cts_n_in(lines.cts), .dsr_n_in(lines.dsr),
    .dcd_n_in(lines.dcd), .ri_n_in(lines.ri), .dtr_n_out(dtr_n_out),
    .rts_n_out(rts_n_out), .rx_error_in(src[2]), .rx_data_ready_in(src[0]),
    .rx_timeout_in(src[3]), .thr_empty_in(src[1]), .rx_threshold_in(rx_threshold_in),
    .tx_serial_in(tx_serial_in), .serial_tx_out(serial_tx_out),
    .tx_allowed_out(tx_allowed_out), .irq_out(irq_out));

  // ***********************************************************
  // Compare and access tasks
  // ***********************************************************
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  task automatic wr(input logic [2:0] i, input logic [7:0] v, input logic cs_n = 1'b0);
    logic [7:0] r;
    logic       o;
    u_host.access(cs_n, 1'b0, i, v, r, o);
  endtask

  task automatic rd(input logic [2:0] i, input logic [7:0] e);
    logic [7:0] r;
    logic       o;
    u_host.access(1'b0, 1'b1, i, 8'h00, r, o);
    chk8(r, e);
    chk1(o, 1'b1);
    chk1(data_oe_out, 1'b0);
  endtask

  // Poll the interrupt line for a bounded number of cycles
  task automatic wait_irq(input logic e);
    for (int n = 0; n < 10 && irq_out !== e; n++) begin
      @(posedge clk_in);
      #1;
    end
    chk1(irq_out, e);
  endtask

  task automatic summarize();
    if (mismatches == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ***********************************************************
  // Watchdog
  // ***********************************************************
  initial begin
    #(25 * 5000);
    mismatches++;
    summarize();
  end

  // ***********************************************************
  // Main sequence
  // ***********************************************************
  initial begin
    repeat (4) @(posedge clk_in);
    #1;
    reset_n_in = 1'b1;
    chk8({6'h00, dtr_n_out, rts_n_out}, 8'h03);
    chk1(serial_tx_out, 1'b1);
    chk1(irq_out, 1'b0);
    chk1(tx_allowed_out, 1'b1);
    wr(UC_MCT_IDX, 8'h03);
    chk8({6'h00, dtr_n_out, rts_n_out}, 8'h00);
    rd(UC_MCT_IDX, 8'h03);
    wr(UC_MCT_IDX, 8'h00, 1'b1);
    rd(UC_MCT_IDX, 8'h03);
    rd(3'h7, 8'h00);
    wr(UC_MCT_IDX, 8'hff);
    rd(UC_MCT_IDX, 8'h33);
    chk8({6'h00, dtr_n_out, rts_n_out}, 8'h03);
    chk1(serial_tx_out, 1'b1);
    wr(UC_MCT_IDX, 8'h03);
    tx_serial_in = 1'b0;
    @(posedge clk_in);
    @(posedge clk_in);
    #1;
    chk1(serial_tx_out, 1'b0);
    rd(UC_MSR_IDX, 8'h00);
    for (int k = 0; k < 6; k++) begin
      lines = pv[k];
      repeat (6) @(posedge clk_in);
      #1;
      rd(UC_MSR_IDX, ev[k]);
    end
    wr(UC_IER_IDX, 8'h08);
    lines.dcd = 1'b1;
    wait_irq(1'b1);
    rd(UC_IIR_IDX, 8'h00);
    rd(UC_MSR_IDX, 8'h38);
    wait_irq(1'b0);
    wr(UC_IIR_IDX, 8'h01);
    wr(UC_MCT_IDX, 8'h20);
    lines.cts = 1'b1;
    repeat (8) @(posedge clk_in);
    #1;
    chk1(irq_out, 1'b0);
    chk1(tx_allowed_out, 1'b0);
    rd(UC_MSR_IDX, 8'h21);
    lines.cts = 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
    chk1(tx_allowed_out, 1'b1);
    rd(UC_MSR_IDX, 8'h31);
    wr(UC_MCT_IDX, 8'h22);
    chk1(rts_n_out, 1'b0);
    rx_threshold_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk1(rts_n_out, 1'b1);
    rx_threshold_in = 1'b0;
    wr(UC_IIR_IDX, 8'h00);
    wr(UC_IER_IDX, 8'h07);
    for (int k = 0; k < 3; k++) begin
      src[k] = 1'b1;
      wait_irq(1'b1);
      rd(UC_IIR_IDX, id[k]);
      src[k] = 1'b0;
      wait_irq(1'b0);
    end
    src[3] = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    chk1(irq_out, 1'b0);
    wr(UC_IIR_IDX, 8'h01);
    wait_irq(1'b1);
    rd(UC_IIR_IDX, 8'hcc);
    src[3] = 1'b0;
    wait_irq(1'b0);
    wr(UC_MCT_IDX, 8'h03);
    src[1] = 1'b1;
    wait_irq(1'b1);
    master_reset_in = 1'b1;
    @(posedge clk_in);
    #1;
    chk1(serial_tx_out, 1'b1);
    chk1(irq_out, 1'b0);
    master_reset_in = 1'b0;
    @(posedge clk_in);
    #1;
    chk1(irq_out, 1'b0);
    chk8({6'h00, dtr_n_out, rts_n_out}, 8'h03);
    rd(UC_MCT_IDX, 8'h00);
    summarize();
  end
endmodule // uart_host_port_and_modem_lines_tb_top

`default_nettype wire

// ==== ucomm_host_model.sv ====
// Host processor model that drives the parallel register bus
`timescale 1ns/1ps
`default_nettype none

module ucomm_host_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  input  wire logic       oe_in,
  output logic            cs_n_out,
  output logic            rd_n_out,
  output logic            wr_n_out,
  output logic [2:0]      sel_out,
  output logic [7:0]      wdata_out
);
  // ***********************************************************
  // Idle bus at time zero
  // ***********************************************************
  initial begin
    {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
    sel_out = 3'h0;
    wdata_out = 8'h00;
  end

  // One access, entered just after a rising edge; strobes held two edges
  task automatic access(input logic cs_n, input logic rd, input logic [2:0] idx,
                        input logic [7:0] wval, output logic [7:0] rval, output logic oe);
    cs_n_out = cs_n;
    sel_out = idx;
    wdata_out = wval;
    rd_n_out = ~rd;
    wr_n_out = rd;
    @(posedge clk_in);
    @(posedge clk_in);
    #1;
    rval = rdata_in;
    oe = oe_in;
    {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
    wdata_out = ~wval;  // Released data lines show no stale value
    @(posedge clk_in);
    #1;
  endtask
endmodule // ucomm_host_model

`default_nettype wire

// ==== ucomm_host_port.sv ====
// Host bus port, modem lines and interrupt output of the serial element
//
// Overview of operation
// - Select lines choose the accessed register
// - Chip select high ignores all strobes
// - Selected read strobe returns addressed register
// - Eight-bit data path driven only during reads
// - Status bit 4 clear-to-send, bit 0 change
// - Status bit 5 data-set-ready, bit 1 change
// - Status bit 7 carrier, bit 3 change
// - Status bit 6 ring, bit 2 rising
// - Clear-to-send change interrupts only without auto mode
// - Other modem changes interrupt when enabled
// - Auto mode lets clear-to-send gate transmitter
// - Terminal-ready follows control bit, off in loop
// - Request-to-send follows bit 1, off in loop
// - Auto mode receiver threshold forces request off
// - Interrupt on five enabled sources
// - Interrupt drops when serviced or reset
// - Master reset clears registers and outputs
// - Selected write strobe loads addressed register
// - Serial output marks high on reset
`timescale 1ns/1ps
`default_nettype none

module ucomm_host_port #(
  parameter int DATA_WIDTH = 8
) (
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic                  master_reset_in,
  input  wire logic                  reg_select_0_in,
  input  wire logic                  reg_select_1_in,
  input  wire logic                  reg_select_2_in,
  input  wire logic                  chip_select_n_in,
  input  wire logic                  read_strobe_n_in,
  input  wire logic                  write_strobe_n_in,
  input  wire logic [DATA_WIDTH-1:0] data_in,
  output logic      [DATA_WIDTH-1:0] data_out,
  output logic                       data_oe_out,
  input  wire logic                  cts_n_in,
  input  wire logic                  dsr_n_in,
  input  wire logic                  dcd_n_in,
  input  wire logic                  ri_n_in,
  output logic                       dtr_n_out,
  output logic                       rts_n_out,
  input  wire logic                  rx_error_in,
  input  wire logic                  rx_data_ready_in,
  input  wire logic                  rx_timeout_in,
  input  wire logic                  thr_empty_in,
  input  wire logic                  rx_threshold_in,
  input  wire logic                  tx_serial_in,
  output logic                       serial_tx_out,
  output logic                       tx_allowed_out,
  output logic                       irq_out
);
  import ucomm_pkg::*;

  // Elaboration check: the register map is byte wide
  if (DATA_WIDTH != 8) begin : g_width_check
    $error("ucomm_host_port supports DATA_WIDTH of 8 only");
  end

  // ***********************************************************
  // Bus decode
  // ***********************************************************
  logic         rst;
  logic [2:0]   addr;
  logic         rd_req;
  logic         wr_req;
  logic         rd_start;
  logic         wr_start;
  ucomm_bus_e   state_ff;
  ucomm_bus_e   nxt_state;

  // Strobes count only while selected, read wins a collision
  assign rst      = !reset_n_in || master_reset_in;
  assign addr     = {reg_select_2_in, reg_select_1_in, reg_select_0_in};
  assign rd_req   = !chip_select_n_in && !read_strobe_n_in;
  assign wr_req   = !chip_select_n_in && !write_strobe_n_in && read_strobe_n_in;
  assign rd_start = (state_ff == UC_BUS_IDLE) && rd_req;
  assign wr_start = (state_ff == UC_BUS_IDLE) && wr_req;

  // Access phase: one action per strobe assertion
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      UC_BUS_IDLE: begin
        if (rd_req) begin
          nxt_state = UC_BUS_READ;
        end else if (wr_req) begin
          nxt_state = UC_BUS_WRITE;
        end
      end
      UC_BUS_READ: begin
        if (!rd_req) begin
          nxt_state = UC_BUS_IDLE;
        end
      end
      UC_BUS_WRITE: begin
        if (!wr_req) begin
          nxt_state = UC_BUS_IDLE;
        end
      end
      default: begin
        nxt_state = UC_BUS_IDLE;
      end
    endcase
  end

  // Phase register
  always_ff @(posedge clk_in) begin
    if (rst) begin
      state_ff <= UC_BUS_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ***********************************************************
  // Modem line synchronisers and change flags
  // ***********************************************************
  ucomm_lines_s lines_pin;
  ucomm_lines_s sync1_ff;
  ucomm_lines_s sync2_ff;
  ucomm_lines_s prev_ff;
  logic [3:0]   delta_set;
  logic [3:0]   delta_ff;
  logic [3:0]   nxt_delta;
  logic         msr_read;
  logic [7:0]   msr_value;

  assign lines_pin = '{dcd: dcd_n_in, ri: ri_n_in, dsr: dsr_n_in, cts: cts_n_in};

  // Two flops before any comparison, idle level is high
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sync1_ff <= '1;
      sync2_ff <= '1;
      prev_ff  <= '1;
    end else begin
      sync1_ff <= lines_pin;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
    end
  end

  // Change events: any level change, ring only on a low-to-high pin
  assign delta_set[UC_MSR_DCTS] = sync2_ff.cts != prev_ff.cts;
  assign delta_set[UC_MSR_DDSR] = sync2_ff.dsr != prev_ff.dsr;
  assign delta_set[UC_MSR_RIUP] = sync2_ff.ri && !prev_ff.ri;
  assign delta_set[UC_MSR_DDCD] = sync2_ff.dcd != prev_ff.dcd;
  assign msr_read = rd_start && (addr == UC_MSR_IDX);

  // Sticky flags: a new event beats the clear of the read
  for (genvar i = 0; i < 4; i++) begin : g_delta
    assign nxt_delta[i] = delta_set[i] || (delta_ff[i] && !msr_read);
  end

  // Flag register
  always_ff @(posedge clk_in) begin
    if (rst) begin
      delta_ff <= 4'h0;
    end else begin
      delta_ff <= nxt_delta;
    end
  end

  // Reported levels are the asserted sense of the pins
  assign msr_value = {!sync2_ff.dcd, !sync2_ff.ri, !sync2_ff.dsr, !sync2_ff.cts,
                      delta_ff};

  // ***********************************************************
  // Control registers
  // ***********************************************************
  logic [7:0] ier_ff;
  logic [7:0] mct_ff;
  logic [7:0] fcr_ff;
  logic       wr_ier;
  logic       wr_mct;
  logic       wr_fcr;

  assign wr_ier = wr_start && (addr == UC_IER_IDX);
  assign wr_mct = wr_start && (addr == UC_MCT_IDX);
  assign wr_fcr = wr_start && (addr == UC_IIR_IDX);

  // Writes take the bus value at the strobe's first cycle
  always_ff @(posedge clk_in) begin
    if (rst) begin
      ier_ff <= UC_IER_RST;
      mct_ff <= UC_MCT_RST;
      fcr_ff <= UC_FCR_RST;
    end else begin
      if (wr_ier) ier_ff <= data_in & UC_IER_MASK;
      if (wr_mct) mct_ff <= data_in & UC_MCT_MASK;
      if (wr_fcr) fcr_ff <= data_in & UC_FCR_MASK;
    end
  end

  // ***********************************************************
  // Interrupt sources and identity
  // ***********************************************************
  logic       fifo_mode;
  logic       loop_mode;
  logic       auto_cts;
  logic       auto_rts;
  logic       modem_pending;
  logic       src_rls;
  logic       src_rda;
  logic       src_tout;
  logic       src_thre;
  logic       src_ms;
  logic [3:0] iir_id;
  logic       irq_ff;

  assign fifo_mode = fcr_ff[UC_FCR_FEN];
  assign loop_mode = mct_ff[UC_MCT_LOOP];
  assign auto_cts  = mct_ff[UC_MCT_AFE] && fifo_mode;
  assign auto_rts  = auto_cts && mct_ff[UC_MCT_RTS];

  // Clear-to-send changes stay silent under automatic flow control
  assign modem_pending = (delta_ff[UC_MSR_DCTS] && !auto_cts) ||
                         delta_ff[UC_MSR_DDSR] || delta_ff[UC_MSR_RIUP] ||
                         delta_ff[UC_MSR_DDCD];

  // Enabled sources; timeout exists only in fifo mode
  assign src_rls  = ier_ff[UC_IER_RLS] && rx_error_in;
  assign src_rda  = ier_ff[UC_IER_RDA] && rx_data_ready_in;
  assign src_tout = ier_ff[UC_IER_RDA] && fifo_mode && rx_timeout_in;
  assign src_thre = ier_ff[UC_IER_THRE] && thr_empty_in;
  assign src_ms   = ier_ff[UC_IER_MS] && modem_pending;

  // Highest priority pending source names the identity
  assign iir_id = src_rls  ? UC_ID_RLS  :
                  src_rda  ? UC_ID_RDA  :
                  src_tout ? UC_ID_TOUT :
                  src_thre ? UC_ID_THRE :
                  src_ms   ? UC_ID_MS   : UC_ID_NONE;

  // Output follows pending sources, so it drops once serviced
  always_ff @(posedge clk_in) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= src_rls || src_rda || src_tout || src_thre || src_ms;
    end
  end
  assign irq_out = irq_ff;

  // ***********************************************************
  // Read path
  // ***********************************************************
  logic [7:0] rd_mux;
  logic [7:0] data_ff;

  // Unmapped indices read as zero
  assign rd_mux = (addr == UC_IER_IDX) ? ier_ff :
                  (addr == UC_IIR_IDX) ? {{2{fifo_mode}}, 2'b00, iir_id} :
                  (addr == UC_MCT_IDX) ? mct_ff :
                  (addr == UC_MSR_IDX) ? msr_value : 8'h00;

  // Read data is caught once, at the strobe's first cycle
  always_ff @(posedge clk_in) begin
    if (rst) begin
      data_ff <= 8'h00;
    end else if (rd_start) begin
      data_ff <= rd_mux;
    end
  end
  assign data_out    = data_ff;
  assign data_oe_out = (state_ff == UC_BUS_READ);

  // ***********************************************************
  // Modem control and serial outputs
  // ***********************************************************
  logic dtr_n_ff;
  logic rts_n_ff;
  logic tx_ff;
  logic nxt_dtr_n;
  logic nxt_rts_n;

  // Loop mode parks both control lines inactive
  assign nxt_dtr_n = !(mct_ff[UC_MCT_DTR] && !loop_mode);
  assign nxt_rts_n = !(mct_ff[UC_MCT_RTS] && !loop_mode &&
                       !(auto_rts && rx_threshold_in));

  // Output flops, all idle high under reset
  always_ff @(posedge clk_in) begin
    if (rst) begin
      dtr_n_ff <= 1'b1;
      rts_n_ff <= 1'b1;
      tx_ff    <= 1'b1;
    end else begin
      dtr_n_ff <= nxt_dtr_n;
      rts_n_ff <= nxt_rts_n;
      tx_ff    <= loop_mode || tx_serial_in;
    end
  end
  assign dtr_n_out     = dtr_n_ff;
  assign rts_n_out     = rts_n_ff;
  assign serial_tx_out = tx_ff;
  assign tx_allowed_out = !auto_cts || !sync2_ff.cts;

  // ***********************************************************
  // Assertions
  // ***********************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence read_begin_s;
    rd_start && !master_reset_in;
  endsequence

  sequence read_drive_s;
    data_oe_out && (data_out == $past(rd_mux));
  endsequence

  read_drive_a: assert property (read_begin_s |=> read_drive_s)
    else $error("read data not driven from addressed register");

  chip_idle_a: assert property (chip_select_n_in |=> !data_oe_out)
    else $error("data driven while chip deselected");

  msr_clear_a: assert property (msr_read && !master_reset_in && delta_set == 4'h0
                                |=> delta_ff == 4'h0)
    else $error("status read left change flags set");

  event_wins_a: assert property (delta_set[UC_MSR_RIUP] && !master_reset_in
                                 |=> delta_ff[UC_MSR_RIUP])
    else $error("ring rising edge flag lost");

  sync_delay_a: assert property (sync2_ff == $past(lines_pin, 2) ||
                                 !$past(reset_n_in, 2))
    else $error("modem inputs not two flops deep");

  ctl_write_a: assert property (wr_mct && !master_reset_in
                                |=> mct_ff == ($past(data_in) & UC_MCT_MASK))
    else $error("control write not taken");

  loop_lines_a: assert property (loop_mode && !master_reset_in
                                 |=> dtr_n_out && rts_n_out)
    else $error("control lines active in loop mode");

  rts_auto_a: assert property (auto_rts && rx_threshold_in |=> rts_n_out)
    else $error("receiver threshold did not hold request off");

  irq_ms_a: assert property (src_ms && !master_reset_in |=> irq_out)
    else $error("modem status interrupt missing");

  cts_quiet_a: assert property (auto_cts && delta_ff[UC_MSR_DCTS] &&
                                !src_rls && !src_rda && !src_tout && !src_thre &&
                                !delta_ff[UC_MSR_DDSR] && !delta_ff[UC_MSR_RIUP] &&
                                !delta_ff[UC_MSR_DDCD] |=> !irq_out)
    else $error("clear-to-send change raised interrupt in auto mode");

  reset_out_a: assert property (master_reset_in
                                |=> dtr_n_out && rts_n_out && serial_tx_out && !irq_out)
    else $error("outputs not at reset levels");

endmodule // ucomm_host_port

`default_nettype wire

// ==== ucomm_pkg.sv ====
// Shared constants, register layout and types of the serial element host port
package ucomm_pkg;

  // ***********************************************************
  // Register indices on the three select lines
  // ***********************************************************
  localparam logic [2:0] UC_IER_IDX = 3'h1;  // Interrupt enable
  localparam logic [2:0] UC_IIR_IDX = 3'h2;  // Read: interrupt identity, write: fifo control
  localparam logic [2:0] UC_MCT_IDX = 3'h4;  // Modem control
  localparam logic [2:0] UC_MSR_IDX = 3'h6;  // Modem line status

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int UC_MSR_DCTS = 0;
  localparam int UC_MSR_DDSR = 1;
  localparam int UC_MSR_RIUP = 2;
  localparam int UC_MSR_DDCD = 3;
  localparam int UC_MCT_DTR  = 0;
  localparam int UC_MCT_RTS  = 1;
  localparam int UC_MCT_LOOP = 4;
  localparam int UC_MCT_AFE  = 5;
  localparam int UC_IER_RDA  = 0;
  localparam int UC_IER_THRE = 1;
  localparam int UC_IER_RLS  = 2;
  localparam int UC_IER_MS   = 3;
  localparam int UC_FCR_FEN  = 0;

  // ***********************************************************
  // Reset values and writable masks
  // ***********************************************************
  localparam logic [7:0] UC_IER_RST  = 8'h00;
  localparam logic [7:0] UC_MCT_RST  = 8'h00;
  localparam logic [7:0] UC_FCR_RST  = 8'h00;
  localparam logic [7:0] UC_IER_MASK = 8'h0f;
  localparam logic [7:0] UC_MCT_MASK = 8'h33;
  localparam logic [7:0] UC_FCR_MASK = 8'h01;

  // ***********************************************************
  // Interrupt identity codes, low nibble
  // ***********************************************************
  localparam logic [3:0] UC_ID_NONE = 4'h1;
  localparam logic [3:0] UC_ID_RLS  = 4'h6;
  localparam logic [3:0] UC_ID_RDA  = 4'h4;
  localparam logic [3:0] UC_ID_TOUT = 4'hc;
  localparam logic [3:0] UC_ID_THRE = 4'h2;
  localparam logic [3:0] UC_ID_MS   = 4'h0;

  // Bus access phases
  typedef enum logic [1:0] {UC_BUS_IDLE, UC_BUS_READ, UC_BUS_WRITE} ucomm_bus_e;

  // Modem status lines, pin polarity (active low)
  typedef struct packed {
    logic dcd;
    logic ri;
    logic dsr;
    logic cts;
  } ucomm_lines_s;

endpackage
